/* File: design/energy_limit_pkg.sv */
// Constants, field layout and decode helpers of the energy limiter.
// Assumes a 20 MHz clock and 16-bit registers at the printed addresses.
`default_nettype none
package energy_limit_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int ACC_W = 24;
   localparam int SAMPLE_W = 8;

   // Register addresses
   localparam logic [9:0] ADDR_CONTROL = 10'h015;
   localparam logic [9:0] ADDR_THRESHOLD = 10'h016;
   localparam logic [9:0] ADDR_TOTAL_ONE = 10'h017;
   localparam logic [9:0] ADDR_TOTAL_TWO = 10'h018;
   localparam logic [9:0] ADDR_LOAD_ENABLE = 10'h200;
   localparam logic [9:0] ADDR_GAIN = 10'h201;

   // Reset values
   localparam logic [15:0] CONTROL_RESET = 16'h0505;
   localparam logic [15:0] THRESHOLD_RESET = 16'h9ba3;

   // Field positions
   localparam int DECR_LSB = 8;
   localparam int WEIGHT_LSB = 6;
   localparam int TICK_SEL_LSB = 4;
   localparam int PERIOD_LSB = 0;
   localparam int LOAD_TWO_BIT = 15;
   localparam int LOAD_ONE_BIT = 14;
   localparam int GAIN_LSB = 0;
   localparam int LIMIT_SHIFT = 7;

   localparam logic [7:0] FULL_SCALE = 8'hff;

   // Timing
   localparam int CLOCK_NS = 50;
   localparam int TICK_NS = 10000;
   localparam int TICK_CYCLES = TICK_NS / CLOCK_NS;
   localparam int SECOND_NS = 1000000000;
   localparam int SECOND_TICKS = SECOND_NS / TICK_NS;
   localparam logic [23:0] ACC_MAX = 24'h7fffff;

   // Full-scale weight as a left shift: x1, x4, x8, x16
   function automatic logic [2:0] weight_shift(input logic [1:0] sel);
      logic [2:0] s;
      s = 3'h0;
      unique case (sel)
         2'h0: s = 3'h0;
         2'h1: s = 3'h2;
         2'h2: s = 3'h3;
         2'h3: s = 3'h4;
      endcase
      return s;
   endfunction

   // Rest tick select as a count of 10 us ticks minus one
   function automatic logic [2:0] step_last(input logic [1:0] sel);
      logic [2:0] s;
      s = 3'h0;
      unique case (sel)
         2'h0: s = 3'h0;
         2'h1: s = 3'h1;
         2'h2: s = 3'h3;
         2'h3: s = 3'h7;
      endcase
      return s;
   endfunction
endpackage
`default_nettype wire

/* File: design/energy_channel.sv */
// One channel: pulse timer, energy accumulator and rest (cool-down) state.
// Assumes a one-cycle tick every 10 us and settings that are steady.
`default_nettype none
module energy_channel
   import energy_limit_pkg::*;
#(
   parameter int SECOND_TICKS_P = SECOND_TICKS
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Timing and sample
   input wire logic tick,
   input wire logic [7:0] sample,
   input wire logic pulse_start,
   input wire logic [11:0] high_time,
   // Settings
   input wire logic [1:0] full_scale_weight,
   input wire logic [1:0] rest_tick_select,
   input wire logic [7:0] rest_decrement_step,
   input wire logic [3:0] rest_period_seconds,
   input wire logic [15:0] energy_limit_value,
   // State
   output logic [15:0] total,
   output logic resting,
   output logic pulse_on
);
   typedef enum logic {ACCUMULATE, REST} chan_state_t;

   chan_state_t state_reg, state_next;
   logic [23:0] acc_reg, acc_next;
   logic [11:0] pulse_cnt_reg, pulse_cnt_next;
   logic pulse_reg, pulse_next;
   logic [16:0] sub_sec_reg, sub_sec_next;
   logic [3:0] sec_reg, sec_next;
   logic [2:0] step_reg, step_next;
   logic [15:0] total_reg, total_next;
   logic [11:0] scaled;
   logic [24:0] sum;
   logic [23:0] limit;

   always_comb
   begin
      scaled = {4'h0, sample};
      if (sample == FULL_SCALE)
         scaled = 12'({4'h0, sample} << weight_shift(full_scale_weight)); // R4
      sum = {1'b0, acc_reg} + {13'h0, scaled};
      limit = {1'b0, energy_limit_value, 7'h0}; // R3
      state_next = state_reg;
      acc_next = acc_reg;
      pulse_cnt_next = pulse_cnt_reg;
      pulse_next = pulse_reg;
      sub_sec_next = sub_sec_reg;
      sec_next = sec_reg;
      step_next = step_reg;
      // High pulse lasts high_time ticks, at least one
      if (pulse_start)
      begin
         pulse_next = 1'b1; // R11
         pulse_cnt_next = (high_time == 12'h0) ? 12'h1 : high_time;
      end
      else if (tick && pulse_reg)
      begin
         pulse_cnt_next = pulse_cnt_reg - 12'h1;
         if (pulse_cnt_reg <= 12'h1)
            pulse_next = 1'b0; // R11
      end
      unique case (state_reg)
         ACCUMULATE:
         begin
            if (rest_period_seconds != 4'h0 && acc_reg > limit)
            begin
               state_next = REST; // R2 R7
               sub_sec_next = 17'h0;
               sec_next = 4'h0;
               step_next = 3'h0;
            end
            else if (tick)
               acc_next = (sum > {1'b0, ACC_MAX}) ? ACC_MAX : sum[23:0]; // R1
         end
         REST:
         begin
            if (rest_period_seconds == 4'h0)
               state_next = ACCUMULATE; // R7
            else if (tick)
            begin
               if (step_reg >= step_last(rest_tick_select))
               begin
                  step_next = 3'h0; // R6
                  if (!pulse_reg) // R5
                  begin
                     if (acc_reg > {16'h0, rest_decrement_step})
                        acc_next = acc_reg - {16'h0, rest_decrement_step};
                     else
                        acc_next = 24'h0; // R12
                  end
               end
               else
                  step_next = step_reg + 3'h1;
               if (sub_sec_reg >= 17'(SECOND_TICKS_P - 1))
               begin
                  sub_sec_next = 17'h0;
                  sec_next = sec_reg + 4'h1;
                  if (sec_reg + 4'h1 >= rest_period_seconds)
                     state_next = ACCUMULATE; // R7 R12
               end
               else
                  sub_sec_next = sub_sec_reg + 17'h1;
            end
         end
      endcase
      total_next = acc_next[22:7]; // R8
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg <= ACCUMULATE;
         acc_reg <= 24'h0;
         pulse_cnt_reg <= 12'h0;
         pulse_reg <= 1'b0;
         sub_sec_reg <= 17'h0;
         sec_reg <= 4'h0;
         step_reg <= 3'h0;
         total_reg <= 16'h0;
      end
      else
      begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         pulse_cnt_reg <= pulse_cnt_next;
         pulse_reg <= pulse_next;
         sub_sec_reg <= sub_sec_next;
         sec_reg <= sec_next;
         step_reg <= step_next;
         total_reg <= total_next;
      end
   end

   assign total = total_reg;
   assign resting = (state_reg == REST);
   assign pulse_on = pulse_reg;
endmodule
`default_nettype wire

/* File: design/load_energy_limiter.sv */
// Two-channel load energy limiter with its register file, tick divider,
// load enables and amplifier gain decode.
// Assumes the serial front end delivers single-cycle register strobes.
`default_nettype none

// Functional notes
// R1 - Outside rest, add each channel's weighted sample every 10 us.
// R2 - Total above the limit puts the channel into rest.
// R3 - Compare against the 16-bit limit times 128.
// R4 - Full-scale samples are weighted by x1, x4, x8 or x16.
// R5 - In rest with pulse off, subtract the decrement each rest tick.
// R6 - Rest tick select gives 10, 20, 40 or 80 us.
// R7 - Rest lasts the programmed seconds; zero disables rest entirely.
// R8 - Each channel's 16-bit total is a read-only register.
// R9 - Load enables at bits 15 and 14, cleared after reset.
// R10 - Gain code decodes to a 4-bit thermometer for 1, 2, 5, 10.
// R11 - High pulse lasts programmed 10 us units; its end is pulse off.
// R12 - Channels independent; decrement stops at zero; resume after rest.
// R13 - Reserved enable and gain bits read zero, writes ignored.
module load_energy_limiter
   import energy_limit_pkg::*;
#(
   parameter int SECOND_TICKS_P = SECOND_TICKS
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register access
   input wire logic [energy_limit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [energy_limit_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [energy_limit_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // Channel samples and load pulse requests
   input wire logic [7:0] sample_one,
   input wire logic [7:0] sample_two,
   input wire logic pulse_start_one,
   input wire logic pulse_start_two,
   input wire logic [11:0] high_time,
   // Channel state
   output logic resting_one,
   output logic resting_two,
   output logic pulse_on_one,
   output logic pulse_on_two,
   // Load and amplifier controls
   output logic load_channel_one_on,
   output logic load_channel_two_on,
   output logic [3:0] amplifier_gain_select
);
   logic [15:0] energy_limit_control_reg, energy_limit_control_next;
   logic [15:0] energy_limit_threshold_reg, energy_limit_threshold_next;
   logic load_one_reg, load_one_next;
   logic load_two_reg, load_two_next;
   logic [1:0] gain_code_reg, gain_code_next;
   logic [3:0] gain_therm_reg, gain_therm_next;
   logic [15:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic [7:0] tick_cnt_reg, tick_cnt_next;
   logic tick_reg, tick_next;
   logic [15:0] total_one, total_two;

   // 10 us tick divider
   always_comb
   begin
      tick_next = 1'b0;
      tick_cnt_next = tick_cnt_reg + 8'h1;
      if (tick_cnt_reg >= 8'(TICK_CYCLES - 1))
      begin
         tick_cnt_next = 8'h0;
         tick_next = 1'b1; // R1
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tick_cnt_reg <= 8'h0;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg <= tick_next;
      end
   end

   // Register writes
   always_comb
   begin
      energy_limit_control_next = energy_limit_control_reg;
      energy_limit_threshold_next = energy_limit_threshold_reg;
      load_one_next = load_one_reg;
      load_two_next = load_two_reg;
      gain_code_next = gain_code_reg;
      if (reg_write)
      begin
         unique case (reg_addr)
            ADDR_CONTROL:
               energy_limit_control_next = reg_wdata;
            ADDR_THRESHOLD:
               energy_limit_threshold_next = reg_wdata;
            ADDR_LOAD_ENABLE:
            begin
               load_one_next = reg_wdata[LOAD_ONE_BIT]; // R9 R13
               load_two_next = reg_wdata[LOAD_TWO_BIT]; // R9 R13
            end
            ADDR_GAIN:
               gain_code_next = reg_wdata[GAIN_LSB +: 2]; // R13
            default:
               energy_limit_control_next = energy_limit_control_reg;
         endcase
      end
      // Thermometer steers the amplifier gain switches
      unique case (gain_code_next)
         2'h0: gain_therm_next = 4'h1; // R10
         2'h1: gain_therm_next = 4'h3; // R10
         2'h2: gain_therm_next = 4'h7; // R10
         2'h3: gain_therm_next = 4'hf; // R10
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         energy_limit_control_reg <= CONTROL_RESET;
         energy_limit_threshold_reg <= THRESHOLD_RESET;
         load_one_reg <= 1'b0; // R9
         load_two_reg <= 1'b0; // R9
         gain_code_reg <= 2'h0;
         gain_therm_reg <= 4'h1;
      end
      else
      begin
         energy_limit_control_reg <= energy_limit_control_next;
         energy_limit_threshold_reg <= energy_limit_threshold_next;
         load_one_reg <= load_one_next;
         load_two_reg <= load_two_next;
         gain_code_reg <= gain_code_next;
         gain_therm_reg <= gain_therm_next;
      end
   end

   // Register reads, answered one cycle after the strobe
   always_comb
   begin
      rvalid_next = reg_read;
      rdata_next = 16'h0;
      if (reg_read)
      begin
         unique case (reg_addr)
            ADDR_CONTROL:
               rdata_next = energy_limit_control_reg;
            ADDR_THRESHOLD:
               rdata_next = energy_limit_threshold_reg;
            ADDR_TOTAL_ONE:
               rdata_next = total_one; // R8
            ADDR_TOTAL_TWO:
               rdata_next = total_two; // R8
            ADDR_LOAD_ENABLE:
            begin
               rdata_next[LOAD_ONE_BIT] = load_one_reg; // R13
               rdata_next[LOAD_TWO_BIT] = load_two_reg; // R13
            end
            ADDR_GAIN:
               rdata_next[GAIN_LSB +: 2] = gain_code_reg; // R13
            default:
               rdata_next = 16'h0;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rdata_reg <= 16'h0;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Each channel keeps its own total and rest state
   energy_channel #(
      .SECOND_TICKS_P(SECOND_TICKS_P)
   ) channel_one (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_reg),
      .sample(sample_one),
      .pulse_start(pulse_start_one),
      .high_time(high_time),
      .full_scale_weight(energy_limit_control_reg[WEIGHT_LSB +: 2]),
      .rest_tick_select(energy_limit_control_reg[TICK_SEL_LSB +: 2]),
      .rest_decrement_step(energy_limit_control_reg[DECR_LSB +: 8]),
      .rest_period_seconds(energy_limit_control_reg[PERIOD_LSB +: 4]),
      .energy_limit_value(energy_limit_threshold_reg),
      .total(total_one),
      .resting(resting_one),
      .pulse_on(pulse_on_one)
   ); // R12

   energy_channel #(
      .SECOND_TICKS_P(SECOND_TICKS_P)
   ) channel_two (
      .clock(clock),
      .rst_n(rst_n),
      .tick(tick_reg),
      .sample(sample_two),
      .pulse_start(pulse_start_two),
      .high_time(high_time),
      .full_scale_weight(energy_limit_control_reg[WEIGHT_LSB +: 2]),
      .rest_tick_select(energy_limit_control_reg[TICK_SEL_LSB +: 2]),
      .rest_decrement_step(energy_limit_control_reg[DECR_LSB +: 8]),
      .rest_period_seconds(energy_limit_control_reg[PERIOD_LSB +: 4]),
      .energy_limit_value(energy_limit_threshold_reg),
      .total(total_two),
      .resting(resting_two),
      .pulse_on(pulse_on_two)
   ); // R12

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign load_channel_one_on = load_one_reg;
   assign load_channel_two_on = load_two_reg;
   assign amplifier_gain_select = gain_therm_reg;
endmodule
`default_nettype wire

/* File: verif/load_energy_limiter_properties.sv */
// Checker of the limiter's register port, enables, gain and rest outputs.
// Sees only the top module's ports; bound to it at the foot.
`default_nettype none
module load_energy_limiter_checker
   import energy_limit_pkg::*;
#(
   parameter int SECOND_TICKS_P = SECOND_TICKS
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [energy_limit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [energy_limit_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [energy_limit_pkg::DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   // Channel and controls
   input wire logic pulse_start_one,
   input wire logic pulse_on_one,
   input wire logic resting_one,
   input wire logic resting_two,
   input wire logic load_channel_one_on,
   input wire logic load_channel_two_on,
   input wire logic [3:0] amplifier_gain_select
);
   logic [15:0] wdata_q;
   logic [9:0] addr_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Last cycle's request, so answers can be tied to it
   always_ff @(posedge clock)
   begin
      wdata_q <= reg_wdata;
      addr_q <= reg_addr;
   end
   read_answer_a: assert property (reg_read |=> reg_rvalid)
      else $error("read without answer");
   answer_cause_a: assert property (reg_rvalid |-> $past(reg_read))
      else $error("answer without read");
   idle_data_a: assert property (!reg_rvalid |-> reg_rdata == 16'h0000)
      else $error("read data not zero between answers");
   gain_code_a: assert property (reg_write && reg_addr == ADDR_GAIN |=>
      amplifier_gain_select == 4'((5'h02 << wdata_q[1:0]) - 5'h01))
      else $error("gain thermometer wrong");
   gain_hold_a: assert property (!(reg_write && reg_addr == ADDR_GAIN)
      |=> $stable(amplifier_gain_select))
      else $error("gain changed without write");
   enable_bits_a: assert property (reg_write &&
      reg_addr == ADDR_LOAD_ENABLE
      |=> {load_channel_two_on, load_channel_one_on} == wdata_q[15:14])
      else $error("load enables wrong");
   enable_reserved_a: assert property (reg_rvalid &&
      addr_q == ADDR_LOAD_ENABLE |-> reg_rdata[13:0] == 14'h0000)
      else $error("enable reserved bits not zero");
   gain_reserved_a: assert property (reg_rvalid && addr_q == ADDR_GAIN
      |-> reg_rdata[15:2] == 14'h0000)
      else $error("gain reserved bits not zero");
   rest_off_a: assert property (reg_write && reg_addr == ADDR_CONTROL &&
      reg_wdata[3:0] == 4'h0 |=> ##1 (!resting_one && !resting_two))
      else $error("rest kept with period zero");
   pulse_rise_a: assert property (pulse_start_one |=> pulse_on_one)
      else $error("pulse did not start");
   cover property (resting_one);
   cover property (reg_rvalid && addr_q == ADDR_TOTAL_ONE);
   cover property ($fell(pulse_on_one));
endmodule
bind load_energy_limiter load_energy_limiter_checker #(
   .SECOND_TICKS_P(SECOND_TICKS_P)) chk (.clock, .rst_n, .reg_addr,
   .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
   .pulse_start_one, .pulse_on_one, .resting_one, .resting_two,
   .load_channel_one_on, .load_channel_two_on, .amplifier_gain_select);
`default_nettype wire

/* File: verif/host_bus_model.sv */
// Host side of the register port: one-cycle strobes, one-cycle answers.
// Assumes each access starts just after a rising clock edge.
`default_nettype none
module host_bus_model
   import energy_limit_pkg::*;
(
   // Clock and answer
   input wire logic clock,
   input wire logic [energy_limit_pkg::DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   // Requests
   output logic [energy_limit_pkg::ADDR_W-1:0] reg_addr,
   output logic [energy_limit_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_write,
   output logic reg_read
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // Released lines flip so a stale value never reads as current
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clock);
      #1;
      reg_write = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(posedge clock);
      #1;
   endtask
   // Answer taken at the edge that samples it valid
   task automatic rd(input logic [9:0] a, output logic [15:0] d,
      output logic v);
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge clock);
      #1;
      reg_read = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
      @(posedge clock);
      d = reg_rdata;
      v = reg_rvalid;
      #1;
   endtask
endmodule
`default_nettype wire

/* File: verif/load_energy_limiter_tb_top.sv */
// Self-checking bench of the energy limiter: register and channel runs.
// Assumes the host model and a second shortened to ten ticks.
`default_nettype none
module load_energy_limiter_tb_top;
   import energy_limit_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d, e;
   logic reg_write, reg_read, reg_rvalid, v;
   logic [7:0] sample_one = 8'h00;
   logic pulse_start_one = 1'b0;
   logic pulse_start_two = 1'b0;
   logic resting_one, resting_two, pulse_on_one, pulse_on_two;
   logic load_channel_one_on, load_channel_two_on;
   logic [3:0] amplifier_gain_select;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int t0;
   always #25 clock = ~clock;
   host_bus_model host (.clock, .reg_rdata, .reg_rvalid, .reg_addr,
      .reg_wdata, .reg_write, .reg_read);
   load_energy_limiter #(.SECOND_TICKS_P(10)) uut (.clock, .rst_n,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .reg_rvalid, .sample_one, .sample_two(8'h00), .pulse_start_one,
      .pulse_start_two, .high_time(12'h003), .resting_one,
      .resting_two, .pulse_on_one, .pulse_on_two, .load_channel_one_on,
      .load_channel_two_on, .amplifier_gain_select);
   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_span(input string n, input int lo, input int hi,
      input int g);
      n_tests++;
      if (g < lo || g > hi)
      begin
         fail_count++;
         $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
      host.rd(a, d, v);
      chk("read answer", 16'h0001, {15'h0000, v});
      chk("read data", e, d);
   endtask
   // Bounded wait on resting_one (0) or pulse_on_one (1)
   task automatic wait_for(input int w, input logic lv, input int lim);
      logic s;
      s = w ? pulse_on_one : resting_one;
      for (int i = 0; i < lim && s !== lv; i++)
      begin
         @(posedge clock);
         #1;
         s = w ? pulse_on_one : resting_one;
      end
      chk("awaited level", {15'h0000, lv}, {15'h0000, s});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (12) @(posedge clock);
      #1;
      rst_n = 1'b1;
      rd_chk(ADDR_CONTROL, CONTROL_RESET);
      rd_chk(ADDR_THRESHOLD, THRESHOLD_RESET);
      rd_chk(ADDR_TOTAL_ONE, 16'h0000);
      rd_chk(ADDR_TOTAL_TWO, 16'h0000);
      rd_chk(ADDR_LOAD_ENABLE, 16'h0000);
      chk("gain", 16'h0001, {12'h000, amplifier_gain_select});
      for (int g = 0; g < 4; g++)
      begin
         host.wr(ADDR_GAIN, 16'hfffc | 16'(g));
         e = 16'((16'h2 << g) - 16'h1);
         chk("gain", e, {12'h000, amplifier_gain_select});
         rd_chk(ADDR_GAIN, 16'(g));
      end
      host.wr(ADDR_LOAD_ENABLE, 16'hffff);
      e = {14'h0000, load_channel_two_on, load_channel_one_on};
      chk("enables", 16'h0003, e);
      rd_chk(ADDR_LOAD_ENABLE, 16'hc000);
      host.wr(ADDR_TOTAL_ONE, 16'h1234);
      rd_chk(ADDR_TOTAL_ONE, 16'h0000);
      rd_chk(10'h3ff, 16'h0000);
      // Third full-scale sample at x4 (3060) passes 16 x 128
      host.wr(ADDR_THRESHOLD, 16'h0010);
      host.wr(ADDR_CONTROL, 16'hff42);
      sample_one = 8'hff;
      wait_for(0, 1'b1, 1000);
      sample_one = 8'h00;
      t0 = cycles;
      rd_chk(ADDR_TOTAL_ONE, 16'h0017);
      rd_chk(ADDR_TOTAL_TWO, 16'h0000);
      chk("rest two", 16'h0000, {15'h0000, resting_two});
      // Twelve decrements of 255 empty the total
      wait_for(0, 1'b0, 5000);
      chk_span("rest length", 3800, 4200, cycles - t0);
      rd_chk(ADDR_TOTAL_ONE, 16'h0000);
      // One x16 sample (4080), then ten decrements at 20 us
      host.wr(ADDR_CONTROL, 16'hffd2);
      sample_one = 8'hff;
      wait_for(0, 1'b1, 2000);
      sample_one = 8'h00;
      rd_chk(ADDR_TOTAL_ONE, 16'h001f);
      wait_for(0, 1'b0, 5000);
      rd_chk(ADDR_TOTAL_ONE, 16'h000b);
      // One x8 sample (2040) on top of 1530
      host.wr(ADDR_CONTROL, 16'hffb2);
      sample_one = 8'hff;
      wait_for(0, 1'b1, 2400);
      rd_chk(ADDR_TOTAL_ONE, 16'h001b);
      host.wr(ADDR_CONTROL, 16'hff00);
      repeat (600) @(posedge clock);
      #1;
      chk("rest disabled", 16'h0000, {15'h0000, resting_one});
      sample_one = 8'h00;
      pulse_start_one = 1'b1;
      pulse_start_two = 1'b1;
      @(posedge clock);
      #1;
      pulse_start_one = 1'b0;
      pulse_start_two = 1'b0;
      t0 = cycles;
      chk("pulse on", 16'h0001, {15'h0000, pulse_on_one});
      chk("pulse two", 16'h0001, {15'h0000, pulse_on_two});
      wait_for(1, 1'b0, 1000);
      chk_span("pulse length", 399, 603, cycles - t0);
      chk("pulse two off", 16'h0000, {15'h0000, pulse_on_two});
      end_of_test();
   end
endmodule
`default_nettype wire
